// ==== dv/cdr_host_model.sv ====
// Purpose: Host side model that issues register writes and reads to the bank.
// Assumes: Strobes are sampled on the rising clock edge.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps

module cdr_host_model (
	input wire logic ref_clk_i, // System clock.
	output logic wr_en_o, // Write strobe.
	output logic rd_en_o, // Read strobe.
	output logic [7:0] addr_o, // Register number.
	output logic [7:0] wdata_o, // Write data.
	input wire logic [7:0] rdata_i // Read data.
);
	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_en_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		wr_en_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		addr_o = a;
		rd_en_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		rd_en_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask

	// High byte goes first so the whole code lands with the low byte.
	task automatic set_code(input logic [9:0] c);
		wr(8'h03, {6'h00, c[9:8]});
		wr(8'h04, c[7:0]);
	endtask
endmodule

// ==== dv/cdr_reg_bank_tb.sv ====
// Purpose: Self-checking bench for the coil driver register bank.
// Assumes: Inputs change one nanosecond after the rising edge.
// Notes:   Fault inputs are driven here in place of the analog monitors.
`timescale 1ns/1ps

module cdr_reg_bank_tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] flt = 5'h00;
	logic wr_en, rd_en, drive_en_o, ring_en_o;
	logic [7:0] addr, wdata, rdata_o, mode_o, reson_o;
	logic [9:0] setpoint_o;
	logic [7:0] ra[6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
	logic [7:0] rv[6] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h83};
	int err_total = 0;
	int cmp_count = 0;

	always #25 ref_clk_i = ~ref_clk_i;

	cdr_host_model i_cdr_host_model (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
		.addr_o(addr), .wdata_o(wdata), .rdata_i(rdata_o));

	cdr_reg_bank i_cdr_reg_bank (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_en_i(wr_en),
		.addr_i(addr), .wdata_i(wdata), .rd_en_i(rd_en), .rdata_o(rdata_o),
		.thermal_i(flt[4]), .short_i(flt[3]), .open_i(flt[2]), .undervolt_i(flt[1]),
		.overcur_i(flt[0]), .setpoint_o(setpoint_o), .drive_en_o(drive_en_o),
		.ring_en_o(ring_en_o), .mode_o(mode_o), .reson_o(reson_o));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_cdr_host_model.rd(a, d);
		chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, d});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hung handshake must not stall the run forever.
	initial begin
		#200000;
		err_total++;
		$display("unexpected watchdog: expected end seen hang");
		end_sim();
	end

	initial begin
		idle(5);
		rst_i = 1'b0;
		for (int i = 0; i < 6; i++) rchk(ra[i], rv[i]);
		chk("ring enable", 16'h0001, 16'(ring_en_o));
		i_cdr_host_model.wr(8'h06, 8'hFF);
		i_cdr_host_model.wr(8'h07, 8'h55);
		chk("mode", 16'h001F, 16'(mode_o));
		chk("resonance", 16'h0055, 16'(reson_o));
		i_cdr_host_model.wr(8'h02, 8'hFC);
		chk("ring enable", 16'h0000, 16'(ring_en_o));
		rchk(8'h02, 8'h00);
		i_cdr_host_model.wr(8'h03, 8'hFF);
		chk("setpoint", 16'h0000, 16'(setpoint_o));
		rchk(8'h03, 8'h03);
		i_cdr_host_model.wr(8'h01, 8'hFF);
		rchk(8'h01, 8'h00);
		rchk(8'h06, 8'h1F);
		i_cdr_host_model.wr(8'h05, 8'hFF);
		rchk(8'h05, 8'h00);
		i_cdr_host_model.wr(8'h04, 8'hF4);
		chk("setpoint", 16'h03F4, 16'(setpoint_o));
		chk("drive enable", 16'h0001, 16'(drive_en_o));
		i_cdr_host_model.set_code(10'h3FF);
		chk("setpoint", 16'h03FF, 16'(setpoint_o));
		i_cdr_host_model.set_code(10'h000);
		chk("drive enable", 16'h0000, 16'(drive_en_o));
		i_cdr_host_model.set_code(10'h1F4);
		idle(1);
		flt = 5'h03;
		idle(1);
		flt = 5'h00;
		idle(1);
		chk("drive enable", 16'h0001, 16'(drive_en_o));
		rchk(8'h05, 8'h03);
		flt = 5'h08;
		idle(1);
		flt = 5'h00;
		idle(1);
		chk("drive enable", 16'h0000, 16'(drive_en_o));
		chk("setpoint", 16'h0000, 16'(setpoint_o));
		rchk(8'h04, 8'h00);
		rchk(8'h05, 8'h0B);
		i_cdr_host_model.set_code(10'h005);
		idle(2);
		rchk(8'h05, 8'h00);
		flt = 5'h10;
		idle(2);
		chk("drive enable", 16'h0000, 16'(drive_en_o));
		rchk(8'h05, 8'h10);
		i_cdr_host_model.set_code(10'h0A0);
		idle(2);
		chk("drive enable", 16'h0000, 16'(drive_en_o));
		flt = 5'h00;
		for (int n = 0; n < 8 && drive_en_o !== 1'b1; n++) idle(1);
		chk("drive enable", 16'h0001, 16'(drive_en_o));
		idle(1);
		rchk(8'h05, 8'h00);
		i_cdr_host_model.wr(8'h02, 8'h01);
		idle(1);
		chk("setpoint", 16'h0000, 16'(setpoint_o));
		chk("drive enable", 16'h0000, 16'(drive_en_o));
		chk("mode", 16'h0000, 16'(mode_o));
		chk("resonance", 16'h0083, 16'(reson_o));
		rchk(8'h02, 8'h02);
		rchk(8'h04, 8'h00);
		// An open coil while active must drop the drive, zero the setpoint and clear the high setpoint byte.
		i_cdr_host_model.set_code(10'h102);
		chk("drive enable", 16'h0001, 16'(drive_en_o));
		flt = 5'h04;
		idle(1);
		flt = 5'h00;
		idle(1);
		chk("drive enable", 16'h0000, 16'(drive_en_o));
		chk("setpoint", 16'h0000, 16'(setpoint_o));
		rchk(8'h03, 8'h00);
		rchk(8'h05, 8'h04);
		end_sim();
	end
endmodule

// ==== hw/cdr_fault_flags.sv ====
// Purpose: Sticky fault flag bits of the coil driver.
// Assumes: Fault inputs are synchronous levels or pulses.
// Notes:   A fault present in the clearing cycle still sets its flag.
`timescale 1ns/1ps

module cdr_fault_flags
	import cdr_pkg::*;
#(
	parameter int NUM_FLAGS = 5
) (
	input wire logic ref_clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic clr_i, // Clear all flags.
	input wire logic [NUM_FLAGS-1:0] set_i, // Fault events.
	output logic [NUM_FLAGS-1:0] flags_o // Sticky flags.
);

	// ----------------------------------------------------------------------
	// Per-bit sticky flags
	// ----------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
			logic flag_ff;
			wire logic nxt_flag = set_i[gi] | (flag_ff & ~clr_i);
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					flag_ff <= 1'b0;
				end else begin
					flag_ff <= nxt_flag;
				end
			end
			assign flags_o[gi] = flag_ff;
		end
	endgenerate

endmodule

// ==== hw/cdr_pkg.sv ====
// Purpose: Types shared by the coil driver register bank.
// Assumes: Nothing beyond the register header.
// Notes:   The fault group travels as one packed struct.
package cdr_pkg;

	typedef enum logic {
		CDR_STANDBY,
		CDR_ACTIVE
	} cdr_state_type;

	typedef struct packed {
		logic thermal;
		logic short_c;
		logic open_c;
		logic undervolt;
		logic overcur;
	} cdr_fault_type;

	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cdr_wr_type;

endpackage

// ==== hw/cdr_reg_bank.sv ====
// Purpose: Software-visible register bank of a voice coil current driver.
// Assumes: A serial bus engine delivers byte writes and register reads as strobes.
// Notes:   Read data is registered; it appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "cdr_regs.svh"

// Behaviour
// - Writing one to control bit 0 restores all registers and enters standby.
// - The soft reset bit clears itself and always reads back zero.
// - Control at 0x02: bit1 ringing enable resets to one, bit0 reset, rest zero.
// - Offset 03 holds setpoint bits 9:8 in bits 1:0; upper bits read zero.
// - Offset 04 holds setpoint bits 7:0, read/write, reset zero.
// - Setpoint is linear, 0.1 mA per code, 0 to 102.3 mA.
// - New setpoint applies only when the low byte write completes.
// - Fault register 0x05: thermal, short, open, undervoltage, overcurrent at bits 4..0.
// - All fault flags clear on the standby to active transition; a fault present in that cycle still sets its flag.
// - After thermal trip, stay in standby until the thermal condition clears.
// - Nonzero setpoint means active with output enabled; zero means standby.
// - Thermal, short or open fault while active drops to standby, clears setpoint.
module cdr_reg_bank
	import cdr_pkg::*;
#(
	parameter int SETPOINT_W = 10
) (
	input wire logic ref_clk_i, // System clock, 20 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic wr_en_i, // Register write strobe.
	input wire logic [7:0] addr_i, // Register number.
	input wire logic [7:0] wdata_i, // Write data.
	input wire logic rd_en_i, // Register read strobe.
	output logic [7:0] rdata_o, // Read data, valid the cycle after rd_en_i.
	input wire logic thermal_i, // Thermal shutdown condition level.
	input wire logic short_i, // Coil short detected.
	input wire logic open_i, // Coil open detected.
	input wire logic undervolt_i, // Undervoltage lockout detected.
	input wire logic overcur_i, // Overcurrent detected.
	output logic [SETPOINT_W-1:0] setpoint_o, // Applied coil current code.
	output logic drive_en_o, // Output stage enable, high when active.
	output logic ring_en_o, // Ringing compensation enable.
	output logic [7:0] mode_o, // Drive mode register contents.
	output logic [7:0] reson_o // Resonance tuning register contents.
);

	// ----------------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------------
	cdr_wr_type wr;
	cdr_fault_type fault_in;
	cdr_state_type state_ff, nxt_state;
	logic ring_en_ff;
	logic [1:0] drv_hi_ff;
	logic [7:0] drv_lo_ff;
	logic [SETPOINT_W-1:0] setpoint_ff, nxt_setpoint;
	logic [7:0] mode_ff;
	logic [7:0] reson_ff;
	logic [7:0] rdata_ff;
	logic drive_en_ff;
	logic [4:0] flags;

	assign wr = '{wr_en: wr_en_i, addr: addr_i, wdata: wdata_i};
	assign fault_in = '{thermal: thermal_i, short_c: short_i, open_c: open_i,
		undervolt: undervolt_i, overcur: overcur_i};

	// ----------------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------------
	wire logic wr_ctrl = wr.wr_en && (wr.addr == `CDR_OFS_CTRL);
	wire logic wr_hi = wr.wr_en && (wr.addr == `CDR_OFS_DRV_HI);
	wire logic wr_lo = wr.wr_en && (wr.addr == `CDR_OFS_DRV_LO);
	wire logic wr_mode = wr.wr_en && (wr.addr == `CDR_OFS_MODE);
	wire logic wr_reson = wr.wr_en && (wr.addr == `CDR_OFS_RESON);
	wire logic soft_reset_bit = wr_ctrl && wr.wdata[`CDR_BIT_SOFT_RST];
	wire logic any_rst = rst_i || soft_reset_bit;
	wire logic hard_fault = fault_in.thermal || fault_in.short_c || fault_in.open_c;
	wire logic fault_drop = (state_ff == CDR_ACTIVE) && hard_fault;
	wire logic [SETPOINT_W-1:0] wr_setpoint = {drv_hi_ff, wr.wdata};
	wire logic go_active = (state_ff == CDR_STANDBY) && (nxt_state == CDR_ACTIVE);

	// The setpoint loads on a low-byte write and clears on a fault drop; a high-byte write is just staged.
	always_comb begin
		nxt_setpoint = setpoint_ff;
		if (fault_drop) begin
			nxt_setpoint = '0;
		end else if (wr_lo) begin
			nxt_setpoint = wr_setpoint;
		end
	end

	// Thermal condition blocks a return to active while it persists.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CDR_STANDBY: begin
				if (nxt_setpoint != '0 && !fault_in.thermal) begin
					nxt_state = CDR_ACTIVE;
				end
			end
			CDR_ACTIVE: begin
				if (fault_drop || nxt_setpoint == '0) begin
					nxt_state = CDR_STANDBY;
				end
			end
			default: nxt_state = CDR_STANDBY;
		endcase
	end

	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (any_rst) begin
			state_ff <= CDR_STANDBY;
			setpoint_ff <= '0;
			drive_en_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			setpoint_ff <= nxt_setpoint;
			drive_en_ff <= (nxt_state == CDR_ACTIVE);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (any_rst) begin
			ring_en_ff <= 1'(`CDR_RST_CTRL >> `CDR_BIT_RING_EN);
			drv_hi_ff <= 2'h0;
			drv_lo_ff <= `CDR_RST_DRV;
			mode_ff <= `CDR_RST_MODE;
			reson_ff <= `CDR_RST_RESON;
		end else begin
			if (wr_ctrl) ring_en_ff <= wr.wdata[`CDR_BIT_RING_EN];
			if (fault_drop) begin
				drv_hi_ff <= 2'h0;
				drv_lo_ff <= 8'h00;
			end else begin
				if (wr_hi) drv_hi_ff <= wr.wdata[1:0];
				if (wr_lo) drv_lo_ff <= wr.wdata;
			end
			if (wr_mode) mode_ff <= wr.wdata & `CDR_MODE_MASK;
			if (wr_reson) reson_ff <= wr.wdata;
		end
	end

	cdr_fault_flags #(
		.NUM_FLAGS(5)
	) u_flags (
		.ref_clk_i(ref_clk_i),
		.rst_i(any_rst),
		.clr_i(go_active),
		.set_i(fault_in),
		.flags_o(flags)
	);

	// ----------------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------------
	wire logic [7:0] rd_mux =
		(addr_i == `CDR_OFS_CTRL) ? {6'h00, ring_en_ff, 1'b0} :
		(addr_i == `CDR_OFS_DRV_HI) ? {6'h00, drv_hi_ff} :
		(addr_i == `CDR_OFS_DRV_LO) ? drv_lo_ff :
		(addr_i == `CDR_OFS_FAULT) ? {3'h0, flags} :
		(addr_i == `CDR_OFS_MODE) ? mode_ff :
		(addr_i == `CDR_OFS_RESON) ? reson_ff : 8'h00;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_en_i) begin
			rdata_ff <= rd_mux;
		end
	end

	assign rdata_o = rdata_ff;
	assign setpoint_o = setpoint_ff;
	assign drive_en_o = drive_en_ff;
	assign ring_en_o = ring_en_ff;
	assign mode_o = mode_ff;
	assign reson_o = reson_ff;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	sequence s_rst_write;
		wr_ctrl && wr.wdata[0];
	endsequence

	property p_soft_reset;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_rst_write |=> (setpoint_o == '0) && !drive_en_o && ring_en_o && (reson_o == 8'h83);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

	property p_rst_self_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		rd_en_i && addr_i == 8'h02 |=> rdata_o[0] == 1'b0;
	endproperty
	a_rst_self_clear: assert property (p_rst_self_clear) else $error("reset bit read one");

	property p_hi_only;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_hi && !wr_lo && !fault_drop && !soft_reset_bit |=> $stable(setpoint_o);
	endproperty
	a_hi_only: assert property (p_hi_only) else $error("high byte changed output");

	property p_lo_apply;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_lo && !fault_drop |=> setpoint_o == $past(wr_setpoint);
	endproperty
	a_lo_apply: assert property (p_lo_apply) else $error("low write not applied");

	property p_active_nonzero;
		@(posedge ref_clk_i) disable iff (rst_i)
		drive_en_o |-> setpoint_o != '0;
	endproperty
	a_active_nonzero: assert property (p_active_nonzero) else $error("active at zero");

	property p_fault_drop;
		@(posedge ref_clk_i) disable iff (rst_i)
		fault_drop && !soft_reset_bit |=> !drive_en_o && setpoint_o == '0 &&
			drv_hi_ff == 2'h0 && drv_lo_ff == 8'h00;
	endproperty
	a_fault_drop: assert property (p_fault_drop) else $error("fault did not drop");

	property p_thermal_block;
		@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == CDR_STANDBY && thermal_i |=> state_ff == CDR_STANDBY;
	endproperty
	a_thermal_block: assert property (p_thermal_block) else $error("active during thermal");

	property p_flags_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		go_active && !soft_reset_bit |=> flags == $past(fault_in);
	endproperty
	a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");

	property p_unused_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
		rd_en_i && addr_i == 8'h01 |=> rdata_o == 8'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused read nonzero");

endmodule

// ==== hw/cdr_regs.svh ====
// Purpose: Register offsets, field positions, reset values for the coil driver register bank.
// Assumes: Byte-wide registers addressed by the serial engine's register number.
// Notes:   Definitions only.
`ifndef CDR_REGS_SVH
`define CDR_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define CDR_OFS_UNUSED 8'h01
`define CDR_OFS_CTRL 8'h02
`define CDR_OFS_DRV_HI 8'h03
`define CDR_OFS_DRV_LO 8'h04
`define CDR_OFS_FAULT 8'h05
`define CDR_OFS_MODE 8'h06
`define CDR_OFS_RESON 8'h07

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CDR_BIT_SOFT_RST 0
`define CDR_BIT_RING_EN 1
`define CDR_BIT_OVERCUR 0
`define CDR_BIT_UNDERVOLT 1
`define CDR_BIT_OPEN 2
`define CDR_BIT_SHORT 3
`define CDR_BIT_THERM 4
`define CDR_MODE_MASK 8'h1F
`define CDR_RST_CTRL 8'h02
`define CDR_RST_DRV 8'h00
`define CDR_RST_FAULT 8'h00
`define CDR_RST_MODE 8'h00
`define CDR_RST_RESON 8'h83

`endif
